// >>> include/ismda_map.vh
// register map, field positions, opcodes and constants of the arithmetic block
`ifndef ISMDA_MAP_VH
`define ISMDA_MAP_VH
`define ISMDA_OFF_CTRL    8'h00
`define ISMDA_OFF_STATUS  8'h04
`define ISMDA_OFF_DEST    8'h08
`define ISMDA_OFF_SRC     8'h0c
`define ISMDA_OFF_ACC     8'h10
`define ISMDA_OFF_DEXT    8'h14
`define ISMDA_OFF_FLAGS   8'h18
`define ISMDA_CTRL_OP_MSB 3
`define ISMDA_CTRL_OP_LSB 0
`define ISMDA_CTRL_WORD   8
`define ISMDA_ST_BUSY     0
`define ISMDA_ST_DIVERR   1
`define ISMDA_F_CF        0
`define ISMDA_F_PF        1
`define ISMDA_F_AF        2
`define ISMDA_F_ZF        3
`define ISMDA_F_SF        4
`define ISMDA_F_OF        5
`define ISMDA_RST_WORD    16'h0000
`define ISMDA_RST_FLAGS   6'h00
`define ISMDA_OP_SUB      4'h0
`define ISMDA_OP_SBB      4'h1
`define ISMDA_OP_DEC      4'h2
`define ISMDA_OP_NEG      4'h3
`define ISMDA_OP_CMP      4'h4
`define ISMDA_OP_DAA      4'h5
`define ISMDA_OP_AAS      4'h6
`define ISMDA_OP_DAS      4'h7
`define ISMDA_OP_MUL      4'h8
`define ISMDA_OP_SIGNED_PRODUCT_OP     4'h9
`define ISMDA_OP_AAM      4'ha
`define ISMDA_OP_DIV      4'hb
`define ISMDA_OP_SIGNED_QUOTIENT_OP     4'hc
`define ISMDA_OP_AAD      4'hd
`define ISMDA_OP_CBW      4'he
`define ISMDA_OP_CWD      4'hf
`define ISMDA_NIBBLE_MAX  4'h9
`define ISMDA_BCD_MAX     8'h99
`define ISMDA_ADJ_LO      8'h06
`define ISMDA_ADJ_HI      8'h60
`define ISMDA_TEN         8'h0a
`define ISMDA_UQ_BYTE_MAX 32'h000000ff
`define ISMDA_UQ_WORD_MAX 32'h0000ffff
`define ISMDA_SQ_BYTE_MAX 32'h0000007f
`define ISMDA_SQ_WORD_MAX 32'h00007fff
`endif

// >>> rtl/ismda_div.v
// sequential restoring divider, one quotient bit per clock
module ismda_div #(
  parameter NUM_W = 32,
  parameter DEN_W = 16,
  parameter CNT_W = 6
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             start,
  input  wire [NUM_W-1:0] dividend,
  input  wire [DEN_W-1:0] divisor,
  output wire             busy,
  output wire             done,
  output wire [NUM_W-1:0] quotient,
  output wire [DEN_W-1:0] remainder
);
  localparam [CNT_W-1:0] STEPS = NUM_W;
  localparam [CNT_W-1:0] ONE   = 1;

  reg [NUM_W-1:0] q_r;
  reg [DEN_W-1:0] rem_r;
  reg [DEN_W-1:0] den_r;
  reg [CNT_W-1:0] cnt_r;
  reg             busy_r;
  reg             done_r;

  // trial subtract; divisor is never zero here, the caller traps that case
  wire [DEN_W:0] trial = {rem_r, q_r[NUM_W-1]};
  wire [DEN_W:0] diff  = trial - {1'b0, den_r};
  wire           fits  = ~diff[DEN_W];

  // shift one dividend bit into the partial remainder per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r    <= {NUM_W{1'b0}};
      rem_r  <= {DEN_W{1'b0}};
      den_r  <= {DEN_W{1'b0}};
      cnt_r  <= {CNT_W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        q_r    <= dividend;
        rem_r  <= {DEN_W{1'b0}};
        den_r  <= divisor;
        cnt_r  <= STEPS;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= fits ? diff[DEN_W-1:0] : trial[DEN_W-1:0];
        q_r   <= {q_r[NUM_W-2:0], fits};
        cnt_r <= cnt_r - ONE;
        if (cnt_r == ONE) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign busy      = busy_r;
  assign done      = done_r;
  assign quotient  = q_r;
  assign remainder = rem_r;
endmodule

// >>> rtl/ismda_top.v
// subtract, multiply, divide and decimal adjust datapath behind an AHB-Lite slave
// How it works
// RULE1: packed add fix turns acc_low into two decimal digits, updates AF CF PF SF ZF.
// RULE2: subtract source from destination, write destination, update all six flags.
// RULE3: subtract with borrow also takes off carry_flag, updates all six flags.
// RULE4: decrement destination; carry_flag kept, other five flags updated.
// RULE5: negate as zero minus operand; carry set unless operand is zero.
// RULE6: negating the most negative value leaves it unchanged and sets overflow.
// RULE7: compare subtracts for flags only; neither operand is written.
// RULE8: unpacked subtract fix gives one digit, upper nibble zero, updates AF CF.
// RULE9: packed subtract fix turns acc_low into two digits, updates AF CF PF SF ZF.
// RULE10: unsigned multiply into acc_high:acc_low or data_ext_word:accumulator_word.
// RULE11: unsigned multiply sets CF and OF when the upper half is nonzero.
// RULE12: signed multiply sets CF and OF when upper half is not sign extension.
// RULE13: unpacked multiply fix gives two digits in acc_high/acc_low, updates PF SF ZF.
// RULE14: unsigned divide gives truncated quotient low and remainder high.
// RULE15: unsigned quotient too large or zero divisor raises the divide trap.
// RULE16: signed quotient beyond plus or minus 127 or 32767 raises the trap.
// RULE17: signed quotient truncates toward zero; remainder takes the dividend sign.
// RULE18: unpacked divide prep rewrites acc_low so the quotient is a digit.
// RULE19: byte sign extend copies acc_low bit 7 into acc_high; flags kept.
// RULE20: word sign extend copies bit 15 into data_ext_word; flags kept.
// RULE21: parity flag set when the low eight result bits have even ones.
// RULE22: carry flag shows a borrow into the top result bit.
// RULE23: half carry flag shows a borrow into the low nibble.
// RULE24: overflow flag shows a signed result that does not fit.
// RULE25: unpacked multiply fix puts acc_low/10 high and acc_low mod 10 low.
// RULE26: unpacked divide prep puts acc_high*10+acc_low into acc_low, clears acc_high.
// RULE27: packed fixes adjust by six low and sixty high on digit overrun or carry.
`include "ismda_map.vh"
module ismda_top (
  input  wire        CORE_CLK,
  input  wire        RSTN,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  output wire        DIVIDE_TRAP,
  output wire        BUSY
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DIV  = 2'b10;

  // even parity of the low byte
  function par8;
    input [7:0] v;
    begin
      par8 = ~^v;
    end
  endfunction

  reg rst_s1_r;
  reg rst_s2_r;

  // reset release through two flops, assertion stays asynchronous
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  reg        wr_pend_r;
  reg        rd_pend_r;
  reg        rd_done_r;
  reg  [7:0] addr_r;
  reg [31:0] hrdata_r;
  reg [15:0] dest_r;
  reg [15:0] src_r;
  reg [15:0] acc_r;
  reg [15:0] dext_r;
  reg  [5:0] flags_r;
  reg        err_r;
  reg        trap_r;
  reg  [1:0] state_r;
  reg        dword_r;
  reg        dsgn_r;
  reg        qneg_r;
  reg        rneg_r;

  // reads take one wait state so the data always comes from a flop
  assign HREADYOUT   = ~(rd_pend_r & ~rd_done_r);
  assign HRESP       = 1'b0;
  assign HRDATA      = hrdata_r;
  assign DIVIDE_TRAP = trap_r;
  assign BUSY        = state_r[1];

  wire addr_ok = HSEL & HREADY & HTRANS[1];
  wire busy    = (state_r == ST_DIV);
  // writes during a divide are dropped, they would race the result
  wire wr_go   = wr_pend_r & ~busy;
  wire launch  = wr_go & (addr_r == `ISMDA_OFF_CTRL);
  wire [3:0] opc  = HWDATA[`ISMDA_CTRL_OP_MSB:`ISMDA_CTRL_OP_LSB];
  wire       wsel = HWDATA[`ISMDA_CTRL_WORD];

  // bus phase tracking
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_done_r <= 1'b0;
      addr_r    <= 8'h00;
    end else if (addr_ok) begin
      wr_pend_r <= HWRITE;
      rd_pend_r <= ~HWRITE;
      rd_done_r <= 1'b0;
      addr_r    <= HADDR[7:0];
    end else if (HREADYOUT) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= 1'b1;
    end
  end

  // read mux, unmapped offsets read zero
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_pend_r && !rd_done_r) begin
      if (addr_r == `ISMDA_OFF_STATUS) begin
        hrdata_r <= {30'h00000000, err_r, busy};
      end else if (addr_r == `ISMDA_OFF_DEST) begin
        hrdata_r <= {16'h0000, dest_r};
      end else if (addr_r == `ISMDA_OFF_SRC) begin
        hrdata_r <= {16'h0000, src_r};
      end else if (addr_r == `ISMDA_OFF_ACC) begin
        hrdata_r <= {16'h0000, acc_r};
      end else if (addr_r == `ISMDA_OFF_DEXT) begin
        hrdata_r <= {16'h0000, dext_r};
      end else if (addr_r == `ISMDA_OFF_FLAGS) begin
        hrdata_r <= {26'h0000000, flags_r};
      end else begin
        hrdata_r <= 32'h00000000;
      end
    end
  end

  wire [7:0] al = acc_r[7:0];
  wire [7:0] ah = acc_r[15:8];
  wire       cf = flags_r[`ISMDA_F_CF];
  wire       af = flags_r[`ISMDA_F_AF];

  // subtractor operands: negate is 0 - x, decrement is x - 1
  reg [15:0] sa;
  reg [15:0] sb;
  always @* begin
    sa = dest_r;
    sb = src_r;
    if (opc == `ISMDA_OP_NEG) begin
      sa = 16'h0000; // RULE5
      sb = dest_r;
    end else if (opc == `ISMDA_OP_DEC) begin
      sb = 16'h0001; // RULE4
    end
  end
  wire        cin   = (opc == `ISMDA_OP_SBB) & cf; // RULE3
  wire [16:0] sub_w = {1'b0, sa} - {1'b0, sb} - {16'h0000, cin};
  wire  [8:0] sub_b = {1'b0, sa[7:0]} - {1'b0, sb[7:0]} - {8'h00, cin};
  wire  [4:0] sub_n = {1'b0, sa[3:0]} - {1'b0, sb[3:0]} - {4'h0, cin};
  // byte operations keep the upper byte of the destination
  wire [15:0] sub_r  = wsel ? sub_w[15:0] : {dest_r[15:8], sub_b[7:0]};
  wire        sub_cf = wsel ? sub_w[16] : sub_b[8]; // RULE22
  wire        sub_af = sub_n[4]; // RULE23
  wire        msb_a  = wsel ? sa[15] : sa[7];
  wire        msb_b  = wsel ? sb[15] : sb[7];
  wire        msb_r  = wsel ? sub_r[15] : sub_r[7];
  // most negative negate: 0 - 0x80 wraps to itself with sign mismatch
  wire        sub_of = (msb_a ^ msb_b) & (msb_r ^ msb_a); // RULE24 RULE6
  wire        sub_zf = wsel ? (sub_r == 16'h0000) : (sub_r[7:0] == 8'h00);

  // decimal adjust terms
  wire       dec_lo = (al[3:0] > `ISMDA_NIBBLE_MAX) | af; // RULE27
  wire       dec_hi = (al > `ISMDA_BCD_MAX) | cf; // RULE27
  wire [7:0] adj    = (dec_lo ? `ISMDA_ADJ_LO : 8'h00) + (dec_hi ? `ISMDA_ADJ_HI : 8'h00);
  wire [7:0] daa_r  = al + adj;
  wire [7:0] das_r  = al - adj;
  wire [7:0] aas_r  = (dec_lo ? (al - `ISMDA_ADJ_LO) : al) & 8'h0f;
  wire [7:0] aam_hi = al / `ISMDA_TEN;
  wire [7:0] aam_lo = al % `ISMDA_TEN;
  wire [15:0] aad_p = {8'h00, ah} * {8'h00, `ISMDA_TEN} + {8'h00, al};

  // multipliers, byte forms use acc_low and the source low byte
  wire        [31:0] umul_w = acc_r * src_r;
  wire        [15:0] umul_b = al * src_r[7:0];
  wire signed [31:0] smul_w = $signed(acc_r) * $signed(src_r);
  wire signed [15:0] smul_b = $signed(al) * $signed(src_r[7:0]);
  wire               is_s   = (opc == `ISMDA_OP_SIGNED_PRODUCT_OP);
  wire        [31:0] prod   = wsel ? (is_s ? smul_w : umul_w) : {16'h0000, (is_s ? smul_b : umul_b)};
  wire               mul_uf = wsel ? (prod[31:16] != 16'h0000) : (prod[15:8] != 8'h00); // RULE11
  wire               mul_sf = wsel ? (prod[31:16] != {16{prod[15]}}) : (prod[15:8] != {8{prod[7]}}); // RULE12

  // divider operands as magnitudes, signs kept for the fix-up
  wire        is_sd   = (opc == `ISMDA_OP_SIGNED_QUOTIENT_OP);
  wire        nneg    = is_sd & (wsel ? dext_r[15] : acc_r[15]);
  wire        dneg    = is_sd & (wsel ? src_r[15] : src_r[7]);
  wire [31:0] num_raw = wsel ? {dext_r, acc_r} : {16'h0000, acc_r};
  wire [31:0] num_mag = nneg ? (32'h00000000 - (wsel ? num_raw : {{16{acc_r[15]}}, acc_r})) : num_raw;
  wire [15:0] den_raw = wsel ? src_r : {8'h00, src_r[7:0]};
  wire [15:0] den_mag = dneg ? (16'h0000 - (wsel ? src_r : {{8{src_r[7]}}, src_r[7:0]})) : den_raw;
  wire        den_zero = (den_raw == 16'h0000);
  wire        is_div   = launch & ((opc == `ISMDA_OP_DIV) | is_sd);
  wire        div_start = is_div & ~den_zero;
  wire        div_done;
  wire [31:0] quot;
  wire [15:0] rem;

  ismda_div #(
    .NUM_W (32),
    .DEN_W (16),
    .CNT_W (6)
  ) u_div (
    .clk       (CORE_CLK),
    .rst_n     (rst_n),
    .start     (div_start),
    .dividend  (num_mag),
    .divisor   (den_mag),
    .busy      (),
    .done      (div_done),
    .quotient  (quot),
    .remainder (rem)
  );

  // quotient range check and sign restore once the divider finishes
  wire [31:0] qlim   = dsgn_r ? (dword_r ? `ISMDA_SQ_WORD_MAX : `ISMDA_SQ_BYTE_MAX)
                              : (dword_r ? `ISMDA_UQ_WORD_MAX : `ISMDA_UQ_BYTE_MAX);
  wire        q_over = (quot > qlim); // RULE15 RULE16
  wire [15:0] q_fix  = qneg_r ? (16'h0000 - quot[15:0]) : quot[15:0]; // RULE17
  wire [15:0] r_fix  = rneg_r ? (16'h0000 - rem) : rem; // RULE17

  reg [15:0] dest_nxt;
  reg [15:0] acc_nxt;
  reg [15:0] dext_nxt;
  reg  [5:0] flags_nxt;
  reg  [7:0] pv;
  reg        psz;

  // next state of the architectural registers
  always @* begin
    dest_nxt  = dest_r;
    acc_nxt   = acc_r;
    dext_nxt  = dext_r;
    flags_nxt = flags_r;
    pv        = 8'h00;
    psz       = 1'b0;
    if (launch) begin
      case (opc)
        `ISMDA_OP_SUB, `ISMDA_OP_SBB, `ISMDA_OP_NEG, `ISMDA_OP_CMP: begin
          if (opc != `ISMDA_OP_CMP) begin
            dest_nxt = sub_r; // RULE2 RULE3 RULE5 RULE7
          end
          flags_nxt[`ISMDA_F_CF] = sub_cf;
          flags_nxt[`ISMDA_F_AF] = sub_af;
          flags_nxt[`ISMDA_F_OF] = sub_of;
          flags_nxt[`ISMDA_F_ZF] = sub_zf;
          flags_nxt[`ISMDA_F_SF] = msb_r;
          flags_nxt[`ISMDA_F_PF] = par8(sub_r[7:0]); // RULE21
        end
        `ISMDA_OP_DEC: begin
          dest_nxt = sub_r; // RULE4
          flags_nxt[`ISMDA_F_AF] = sub_af;
          flags_nxt[`ISMDA_F_OF] = sub_of;
          flags_nxt[`ISMDA_F_ZF] = sub_zf;
          flags_nxt[`ISMDA_F_SF] = msb_r;
          flags_nxt[`ISMDA_F_PF] = par8(sub_r[7:0]);
        end
        `ISMDA_OP_DAA, `ISMDA_OP_DAS: begin
          pv = (opc == `ISMDA_OP_DAA) ? daa_r : das_r; // RULE1 RULE9
          psz = 1'b1;
          acc_nxt = {ah, pv};
          flags_nxt[`ISMDA_F_AF] = dec_lo;
          flags_nxt[`ISMDA_F_CF] = dec_hi;
        end
        `ISMDA_OP_AAS: begin
          acc_nxt = {ah, aas_r}; // RULE8
          flags_nxt[`ISMDA_F_AF] = dec_lo;
          flags_nxt[`ISMDA_F_CF] = dec_lo;
        end
        `ISMDA_OP_MUL, `ISMDA_OP_SIGNED_PRODUCT_OP: begin
          acc_nxt = prod[15:0]; // RULE10
          if (wsel) begin
            dext_nxt = prod[31:16];
          end
          flags_nxt[`ISMDA_F_CF] = is_s ? mul_sf : mul_uf;
          flags_nxt[`ISMDA_F_OF] = is_s ? mul_sf : mul_uf;
        end
        `ISMDA_OP_AAM: begin
          pv = aam_lo; // RULE13 RULE25
          psz = 1'b1;
          acc_nxt = {aam_hi, aam_lo};
        end
        `ISMDA_OP_AAD: begin
          pv = aad_p[7:0]; // RULE18 RULE26
          psz = 1'b1;
          acc_nxt = {8'h00, aad_p[7:0]};
        end
        `ISMDA_OP_CBW: begin
          acc_nxt = {{8{al[7]}}, al}; // RULE19
        end
        `ISMDA_OP_CWD: begin
          dext_nxt = {16{acc_r[15]}}; // RULE20
        end
        default: begin
          dest_nxt = dest_r;
        end
      endcase
      if (psz) begin
        flags_nxt[`ISMDA_F_PF] = par8(pv);
        flags_nxt[`ISMDA_F_SF] = pv[7];
        flags_nxt[`ISMDA_F_ZF] = (pv == 8'h00);
      end
    end else if (div_done && !q_over) begin
      if (dword_r) begin
        acc_nxt  = q_fix; // RULE14
        dext_nxt = r_fix;
      end else begin
        acc_nxt = {r_fix[7:0], q_fix[7:0]}; // RULE14
      end
    end else if (wr_go) begin
      if (addr_r == `ISMDA_OFF_DEST) begin
        dest_nxt = HWDATA[15:0];
      end else if (addr_r == `ISMDA_OFF_ACC) begin
        acc_nxt = HWDATA[15:0];
      end else if (addr_r == `ISMDA_OFF_DEXT) begin
        dext_nxt = HWDATA[15:0];
      end else if (addr_r == `ISMDA_OFF_FLAGS) begin
        flags_nxt = HWDATA[5:0];
      end
    end
  end

  // architectural registers and divide sequencing
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dest_r  <= `ISMDA_RST_WORD;
      src_r   <= `ISMDA_RST_WORD;
      acc_r   <= `ISMDA_RST_WORD;
      dext_r  <= `ISMDA_RST_WORD;
      flags_r <= `ISMDA_RST_FLAGS;
      err_r   <= 1'b0;
      trap_r  <= 1'b0;
      state_r <= ST_IDLE;
      dword_r <= 1'b0;
      dsgn_r  <= 1'b0;
      qneg_r  <= 1'b0;
      rneg_r  <= 1'b0;
    end else begin
      dest_r  <= dest_nxt;
      acc_r   <= acc_nxt;
      dext_r  <= dext_nxt;
      flags_r <= flags_nxt;
      trap_r  <= 1'b0;
      if (wr_go && (addr_r == `ISMDA_OFF_SRC)) begin
        src_r <= HWDATA[15:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            err_r <= 1'b0;
          end
          if (is_div && den_zero) begin
            trap_r <= 1'b1; // RULE15 RULE16
            err_r  <= 1'b1;
          end else if (div_start) begin
            state_r <= ST_DIV;
            dword_r <= wsel;
            dsgn_r  <= is_sd;
            qneg_r  <= nneg ^ dneg;
            rneg_r  <= nneg;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state_r <= ST_IDLE;
            if (q_over) begin
              trap_r <= 1'b1; // RULE15 RULE16
              err_r  <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> tb/ismda_chk.sv
// concurrent checks on the arithmetic block's bus, busy and trap ports
module ismda_chk (
  input wire        CORE_CLK,
  input wire        RSTN,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [2:0]  HSIZE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire        DIVIDE_TRAP,
  input wire        BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] bcnt_r;
  wire        rd_t = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  wire        wr_t = HSEL & HREADY & HTRANS[1] & HWRITE;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // busy run length; the divide span is a fixed count, too long for a repetition
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN)
      bcnt_r <= 6'h00;
    else
      bcnt_r <= BUSY ? bcnt_r + 6'h01 : 6'h00;
  end
  property p_rd_wait; rd_t |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero; wr_t |=> HREADYOUT; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_okay; HREADYOUT |-> !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rdata_hold; !$stable(HRDATA) |-> !$past(HREADYOUT); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside a read");
  property p_trap_pulse; DIVIDE_TRAP |=> !DIVIDE_TRAP; endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than one cycle");
  property p_trap_idle; DIVIDE_TRAP |-> !BUSY; endproperty
  a_trap_idle: assert property (p_trap_idle) else $error("trap while busy");
  property p_trap_cause; DIVIDE_TRAP |-> ($past(BUSY) || $past(wr_t, 2)); endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without a divide");
  property p_busy_len; $fell(BUSY) |-> bcnt_r == 6'h21; endproperty
  a_busy_len: assert property (p_busy_len) else $error("divide span wrong");
  property p_busy_start; $rose(BUSY) |-> $past(wr_t, 2); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without a launch");
  c_read: cover property (rd_t);
  c_div_end: cover property ($fell(BUSY));
  c_trap: cover property (DIVIDE_TRAP);
endmodule

bind ismda_top ismda_chk u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DIVIDE_TRAP(DIVIDE_TRAP), .BUSY(BUSY));

// >>> tb/ismda_top_tb.sv
// self-checking bench: register accesses over the bus, one op at a time
`include "ismda_map.vh"
module ismda_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  wire  [31:0] HRDATA;
  wire         HREADYOUT;
  wire         HRESP;
  wire         DIVIDE_TRAP;
  wire         BUSY;
  int          failures = 0;
  int          n_compared = 0;
  int          n_trap = 0;

  // bus ready comes straight back from the single slave
  ismda_top u_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DIVIDE_TRAP(DIVIDE_TRAP), .BUSY(BUSY));

  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  // count trap pulses so each divide's outcome can be checked
  always @(posedge CORE_CLK) if (DIVIDE_TRAP === 1'b1) n_trap++;

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rv = HRDATA;
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk($sformatf("reg %h", a), v, e);
  endtask

  // load operands and flags, launch, optionally poke DEST while busy, wait idle
  task automatic run(input logic [3:0] op, input logic w, input logic [15:0] d, input logic [15:0] s,
                     input logic [15:0] a, input logic [15:0] x, input logic [5:0] f, input logic pk);
    logic [31:0] v;
    ahb(1'b1, `ISMDA_OFF_DEST, {16'h0, d}, v);
    ahb(1'b1, `ISMDA_OFF_SRC, {16'h0, s}, v);
    ahb(1'b1, `ISMDA_OFF_ACC, {16'h0, a}, v);
    ahb(1'b1, `ISMDA_OFF_DEXT, {16'h0, x}, v);
    ahb(1'b1, `ISMDA_OFF_FLAGS, {26'h0, f}, v);
    ahb(1'b1, `ISMDA_OFF_CTRL, {23'h0, w, 4'h0, op}, v);
    if (pk) ahb(1'b1, `ISMDA_OFF_DEST, 32'hbeef, v);
    do ahb(1'b0, `ISMDA_OFF_STATUS, 32'h0, v); while (v[0] !== 1'b0);
  endtask

  // subtract flags worked out bit by bit: {of, sf, zf, af, pf, cf}
  function automatic logic [31:0] fs(input logic w, input logic [15:0] a, input logic [15:0] b, input logic ci);
    logic [16:0] r;
    logic [4:0]  h;
    logic [15:0] p;
    logic [15:0] q;
    int          m;
    m = w ? 15 : 7;
    p = w ? a : {8'h0, a[7:0]};
    q = w ? b : {8'h0, b[7:0]};
    r = {1'b0, p} - {1'b0, q} - {16'h0, ci};
    h = {1'b0, p[3:0]} - {1'b0, q[3:0]} - {4'h0, ci};
    return {26'h0, (p[m] != q[m]) && (r[m] != p[m]), r[m], (w ? r[15:0] : {8'h0, r[7:0]}) == 16'h0,
            h[4], ~^r[7:0], r[16]};
  endfunction

  initial begin
    #100us;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results;
  end

  initial begin
    int t0;
    repeat (16) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    HSEL <= 1'b1;
    run(`ISMDA_OP_SUB, 1'b0, 16'h1200, 16'h0001, 16'h0, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_DEST, 32'h12ff);
    cr(`ISMDA_OFF_FLAGS, fs(1'b0, 16'h1200, 16'h0001, 1'b0));
    run(`ISMDA_OP_SBB, 1'b1, 16'h8000, 16'h0001, 16'h0, 16'h0, 6'h01, 1'b0);
    cr(`ISMDA_OFF_DEST, 32'h7ffe);
    cr(`ISMDA_OFF_FLAGS, fs(1'b1, 16'h8000, 16'h0001, 1'b1));
    run(`ISMDA_OP_DEC, 1'b0, 16'h0080, 16'h0, 16'h0, 16'h0, 6'h01, 1'b0);
    cr(`ISMDA_OFF_DEST, 32'h007f);
    cr(`ISMDA_OFF_FLAGS, fs(1'b0, 16'h0080, 16'h0001, 1'b0) | 32'h1);
    run(`ISMDA_OP_NEG, 1'b0, 16'h0080, 16'h0, 16'h0, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_DEST, 32'h0080);
    cr(`ISMDA_OFF_FLAGS, fs(1'b0, 16'h0, 16'h0080, 1'b0));
    run(`ISMDA_OP_NEG, 1'b1, 16'h0, 16'h0, 16'h0, 16'h0, 6'h01, 1'b0);
    cr(`ISMDA_OFF_FLAGS, fs(1'b1, 16'h0, 16'h0, 1'b0));
    run(`ISMDA_OP_CMP, 1'b1, 16'h0005, 16'h0007, 16'h0, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_DEST, 32'h0005);
    cr(`ISMDA_OFF_FLAGS, fs(1'b1, 16'h0005, 16'h0007, 1'b0));
    $display("test subtract done");
    run(`ISMDA_OP_DAA, 1'b0, 16'h0, 16'h0, 16'h129b, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h1201);
    cr(`ISMDA_OFF_FLAGS, 32'h05);
    run(`ISMDA_OP_AAS, 1'b0, 16'h0, 16'h0, 16'h340f, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h3409);
    cr(`ISMDA_OFF_FLAGS, 32'h05);
    run(`ISMDA_OP_DAS, 1'b0, 16'h0, 16'h0, 16'h00a5, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h0045);
    cr(`ISMDA_OFF_FLAGS, 32'h01);
    run(`ISMDA_OP_AAM, 1'b0, 16'h0, 16'h0, 16'h0051, 16'h0, 6'h3f, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h0801);
    cr(`ISMDA_OFF_FLAGS, 32'h25);
    run(`ISMDA_OP_AAD, 1'b0, 16'h0, 16'h0, 16'h0705, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h004b);
    cr(`ISMDA_OFF_FLAGS, 32'h02);
    $display("test decimal done");
    run(`ISMDA_OP_MUL, 1'b0, 16'h0, 16'h0002, 16'h0080, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h0100);
    cr(`ISMDA_OFF_FLAGS, 32'h21);
    run(`ISMDA_OP_MUL, 1'b1, 16'h0, 16'hffff, 16'hffff, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_DEXT, 32'hfffe);
    run(`ISMDA_OP_SIGNED_PRODUCT_OP, 1'b0, 16'h0, 16'h0002, 16'h00ff, 16'h0, 6'h21, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'hfffe);
    cr(`ISMDA_OFF_FLAGS, 32'h00);
    run(`ISMDA_OP_CBW, 1'b0, 16'h0, 16'h0, 16'h1280, 16'h0, 6'h3f, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'hff80);
    run(`ISMDA_OP_CWD, 1'b1, 16'h0, 16'h0, 16'h8000, 16'h1234, 6'h2a, 1'b0);
    cr(`ISMDA_OFF_DEXT, 32'hffff);
    cr(`ISMDA_OFF_FLAGS, 32'h2a);
    $display("test multiply done");
    run(`ISMDA_OP_DIV, 1'b0, 16'h1111, 16'h0007, 16'h03e8, 16'h0, 6'h00, 1'b1);
    cr(`ISMDA_OFF_ACC, 32'h068e);
    cr(`ISMDA_OFF_DEST, 32'h1111);
    run(`ISMDA_OP_DIV, 1'b1, 16'h0, 16'h0010, 16'h0, 16'h0001, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h1000);
    t0 = n_trap;
    run(`ISMDA_OP_DIV, 1'b0, 16'h0, 16'h0002, 16'h0400, 16'h0, 6'h00, 1'b0);
    chk("trap", 32'(n_trap - t0), 32'h1);
    cr(`ISMDA_OFF_STATUS, 32'h2);
    run(`ISMDA_OP_DIV, 1'b1, 16'h0, 16'h0, 16'h1234, 16'h0, 6'h00, 1'b0);
    chk("trap", 32'(n_trap - t0), 32'h2);
    run(`ISMDA_OP_SIGNED_QUOTIENT_OP, 1'b1, 16'h0, 16'h0002, 16'hfff9, 16'hffff, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'hfffd);
    cr(`ISMDA_OFF_DEXT, 32'hffff);
    run(`ISMDA_OP_SIGNED_QUOTIENT_OP, 1'b0, 16'h0, 16'h0002, 16'h00fe, 16'h0, 6'h00, 1'b0);
    cr(`ISMDA_OFF_ACC, 32'h007f);
    run(`ISMDA_OP_SIGNED_QUOTIENT_OP, 1'b0, 16'h0, 16'h0002, 16'hff00, 16'h0, 6'h00, 1'b0);
    run(`ISMDA_OP_SIGNED_QUOTIENT_OP, 1'b1, 16'h0, 16'h0002, 16'h0000, 16'hffff, 6'h00, 1'b0);
    chk("trap", 32'(n_trap - t0), 32'h4);
    cr(8'h1c, 32'h0);
    $display("test divide done");
    results;
  end
endmodule
